// [design/dtc_timer.sv]
// Top of the down timer: AXI4-Lite register slave, mode control, capture.
// Assumes a 25 MHz aclk, synchronous active-low reset, asynchronous timer pin.
`timescale 1ns/1ps
`include "dtc_consts.svh"
module dtc_timer #(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              timer_pin,
    output logic                   timer_irq
);
    // Address decode shared by the write and read paths
    function automatic dtc_pkg::dtc_sel_t reg_sel(input logic [ADDR_W-1:0] a);
        logic [7:0] a8;
        a8 = 8'(a);
        if (a != ADDR_W'(a8)) begin
            reg_sel = dtc_pkg::DTC_SEL_NONE;
        end else begin
            case (a8)
                `DTC_ADDR_CTRL:   reg_sel = dtc_pkg::DTC_SEL_CTRL;
                `DTC_ADDR_COUNT:  reg_sel = dtc_pkg::DTC_SEL_COUNT;
                `DTC_ADDR_RELCAP: reg_sel = dtc_pkg::DTC_SEL_RELCAP;
                `DTC_ADDR_GIE:    reg_sel = dtc_pkg::DTC_SEL_GIE;
                default:          reg_sel = dtc_pkg::DTC_SEL_NONE;
            endcase
        end
    endfunction

    // Control and status state
    logic        pwm_mode_bit_r;
    logic        capture_mode_bit_r;
    logic        edge_select_bit_r;
    logic        run_or_underflow_flag_r;
    logic        timer_irq_pending_r;
    logic        timer_irq_enable_r;
    logic        global_irq_enable_r;
    logic [15:0] reload_capture_reg_r;
    logic [15:0] cnt_q;
    logic        irq_r;

    // Bus state
    dtc_pkg::dtc_bus_t   wst_r;
    dtc_pkg::dtc_bus_t   rst_r;
    logic                awready_r;
    logic                wready_r;
    logic                aw_got_r;
    logic                w_got_r;
    logic [ADDR_W-1:0]   awaddr_r;
    logic [31:0]         wdata_r;
    logic [3:0]          wstrb_r;
    logic [1:0]          bresp_r;
    logic                bvalid_r;
    logic                rvalid_r;
    logic                arready_r;
    logic [31:0]         rdata_r;
    logic [1:0]          rresp_r;

    // Write decode
    wire aw_fire = s_axi_awvalid && awready_r;
    wire w_fire  = s_axi_wvalid && wready_r;
    wire wr_do   = aw_got_r && w_got_r && (wst_r == dtc_pkg::DTC_BUS_IDLE);
    dtc_pkg::dtc_sel_t wsel;
    dtc_pkg::dtc_sel_t rsel;
    assign wsel = reg_sel(awaddr_r);
    assign rsel = reg_sel(s_axi_araddr);
    wire ctrl_wr = wr_do && (wsel == dtc_pkg::DTC_SEL_CTRL) && wstrb_r[0];
    wire gie_wr  = wr_do && (wsel == dtc_pkg::DTC_SEL_GIE) && wstrb_r[0];
    wire cnt_wr  = wr_do && (wsel == dtc_pkg::DTC_SEL_COUNT) && (|wstrb_r[1:0]);
    wire rc_wr   = wr_do && (wsel == dtc_pkg::DTC_SEL_RELCAP) && (|wstrb_r[1:0]);
    wire [15:0] cnt_wval = {wstrb_r[1] ? wdata_r[15:8] : cnt_q[15:8],
                            wstrb_r[0] ? wdata_r[7:0] : cnt_q[7:0]};
    wire [15:0] rc_wval  = {wstrb_r[1] ? wdata_r[15:8] : reload_capture_reg_r[15:8],
                            wstrb_r[0] ? wdata_r[7:0] : reload_capture_reg_r[7:0]};

    // Mode decode
    dtc_pkg::dtc_mode_t mode;
    assign mode = dtc_pkg::dtc_mode_t'({pwm_mode_bit_r, capture_mode_bit_r,
                                        edge_select_bit_r});
    wire cap_mode = capture_mode_bit_r;
    wire evt_mode = !pwm_mode_bit_r && !capture_mode_bit_r;
    wire rld_mode = pwm_mode_bit_r && !capture_mode_bit_r;

    // Pin edges, qualified by the live edge selection
    logic pin_rise;
    logic pin_fall;
    dtc_pin_sync u_sync (
        .clk    (aclk),
        .rst_n  (aresetn),
        .pin    (timer_pin),
        .rise_r (pin_rise),
        .fall_r (pin_fall)
    );
    wire qual_edge = edge_select_bit_r ? pin_fall : pin_rise;

    // Counting source per mode
    wire dec_en = cap_mode
               || (evt_mode && run_or_underflow_flag_r && qual_edge)
               || (rld_mode && run_or_underflow_flag_r);
    logic uflow;
    dtc_down_counter #(.W(16)) u_cnt (
        .clk        (aclk),
        .rst_n      (aresetn),
        .load_en    (cnt_wr),
        .load_val   (cnt_wval),
        .dec_en     (dec_en),
        .use_reload (!cap_mode),
        .reload_val (reload_capture_reg_r),
        .cnt_r      (cnt_q),
        .uflow      (uflow)
    );
    wire cnt_uflow = uflow && !cnt_wr;
    wire cap_evt   = cap_mode && qual_edge;

    // Hardware events win over a software clear in the same cycle
    wire run_nxt  = (ctrl_wr ? wdata_r[`DTC_BIT_RUN] : run_or_underflow_flag_r)
                    | (cap_mode && cnt_uflow);
    wire pend_nxt = (ctrl_wr ? wdata_r[`DTC_BIT_PEND] : timer_irq_pending_r)
                    | cap_evt | (!cap_mode && cnt_uflow);

    wire pend_any = timer_irq_pending_r || (cap_mode && run_or_underflow_flag_r);
    wire irq_nxt  = pend_any && timer_irq_enable_r && global_irq_enable_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_mode_bit_r          <= 1'b0;
            capture_mode_bit_r      <= 1'b0;
            edge_select_bit_r       <= 1'b0;
            run_or_underflow_flag_r <= 1'b0;
            timer_irq_pending_r     <= 1'b0;
            timer_irq_enable_r      <= 1'b0;
            global_irq_enable_r     <= 1'b0;
            irq_r                   <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                pwm_mode_bit_r     <= wdata_r[`DTC_BIT_PWM];
                capture_mode_bit_r <= wdata_r[`DTC_BIT_CAP];
                edge_select_bit_r  <= wdata_r[`DTC_BIT_EDGE];
                timer_irq_enable_r <= wdata_r[`DTC_BIT_EN];
            end
            if (gie_wr) begin
                global_irq_enable_r <= wdata_r[`DTC_BIT_GIE];
            end
            run_or_underflow_flag_r <= run_nxt;
            timer_irq_pending_r     <= pend_nxt;
            irq_r                   <= irq_nxt;
        end
    end

    // Capture beats a software write to the same register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reload_capture_reg_r <= `DTC_RC_RST;
        end else if (cap_evt) begin
            reload_capture_reg_r <= cnt_q;
        end else if (rc_wr) begin
            reload_capture_reg_r <= rc_wval;
        end
    end

    // Write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_r     <= dtc_pkg::DTC_BUS_IDLE;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            bresp_r   <= `DTC_RESP_OKAY;
            bvalid_r  <= 1'b0;
        end else begin
            if (aw_fire) begin
                aw_got_r  <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
                awready_r <= 1'b0;
            end
            if (w_fire) begin
                w_got_r  <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
                wready_r <= 1'b0;
            end
            case (wst_r)
                dtc_pkg::DTC_BUS_IDLE: begin
                    if (wr_do) begin
                        wst_r    <= dtc_pkg::DTC_BUS_RESP;
                        bvalid_r <= 1'b1;
                        aw_got_r <= 1'b0;
                        w_got_r  <= 1'b0;
                        bresp_r  <= (wsel == dtc_pkg::DTC_SEL_NONE) ?
                                    `DTC_RESP_SLVERR : `DTC_RESP_OKAY;
                    end
                end
                dtc_pkg::DTC_BUS_RESP: begin
                    if (s_axi_bready) begin
                        wst_r     <= dtc_pkg::DTC_BUS_IDLE;
                        bvalid_r  <= 1'b0;
                        awready_r <= 1'b1;
                        wready_r  <= 1'b1;
                    end
                end
                default: wst_r <= dtc_pkg::DTC_BUS_IDLE;
            endcase
        end
    end

    // Read mux, sampled when the address is taken
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (rsel)
            dtc_pkg::DTC_SEL_CTRL: begin
                rd_mux[`DTC_BIT_PWM]  = pwm_mode_bit_r;
                rd_mux[`DTC_BIT_CAP]  = capture_mode_bit_r;
                rd_mux[`DTC_BIT_EDGE] = edge_select_bit_r;
                rd_mux[`DTC_BIT_RUN]  = run_or_underflow_flag_r;
                rd_mux[`DTC_BIT_PEND] = timer_irq_pending_r;
                rd_mux[`DTC_BIT_EN]   = timer_irq_enable_r;
            end
            dtc_pkg::DTC_SEL_COUNT:  rd_mux[15:0] = cnt_q;
            dtc_pkg::DTC_SEL_RELCAP: rd_mux[15:0] = reload_capture_reg_r;
            dtc_pkg::DTC_SEL_GIE:    rd_mux[`DTC_BIT_GIE] = global_irq_enable_r;
            default:                 rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_r     <= dtc_pkg::DTC_BUS_IDLE;
            arready_r <= 1'b1;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `DTC_RESP_OKAY;
            rvalid_r  <= 1'b0;
        end else begin
            case (rst_r)
                dtc_pkg::DTC_BUS_IDLE: begin
                    if (s_axi_arvalid) begin
                        rst_r     <= dtc_pkg::DTC_BUS_RESP;
                        rvalid_r  <= 1'b1;
                        arready_r <= 1'b0;
                        rdata_r   <= rd_mux;
                        rresp_r   <= (rsel == dtc_pkg::DTC_SEL_NONE) ?
                                     `DTC_RESP_SLVERR : `DTC_RESP_OKAY;
                    end
                end
                dtc_pkg::DTC_BUS_RESP: begin
                    if (s_axi_rready) begin
                        rst_r     <= dtc_pkg::DTC_BUS_IDLE;
                        rvalid_r  <= 1'b0;
                        arready_r <= 1'b1;
                    end
                end
                default: rst_r <= dtc_pkg::DTC_BUS_IDLE;
            endcase
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign timer_irq     = irq_r;

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    reset_values_a: assert property ($rose(aresetn) |->
        cnt_q == `DTC_CNT_RST && reload_capture_reg_r == `DTC_RC_RST)
        else $error("reset values wrong");
    capture_copy_a: assert property (cap_evt |=>
        reload_capture_reg_r == $past(cnt_q))
        else $error("capture did not copy the count");
    capture_run_a: assert property (cap_mode && !cnt_wr && cnt_q != 16'h0000 |=>
        cnt_q == $past(cnt_q) - 16'h0001)
        else $error("capture mode counter not decrementing");
    event_hold_a: assert property (evt_mode && !qual_edge && !cnt_wr |=>
        $stable(cnt_q))
        else $error("event counter moved without an edge");
    event_reload_a: assert property (evt_mode && dec_en && cnt_q == 16'h0000
        && !cnt_wr |=> cnt_q == $past(reload_capture_reg_r) && timer_irq_pending_r)
        else $error("event underflow did not reload");
    event_zero_a: assert property (evt_mode && run_or_underflow_flag_r && !cnt_wr
        && cnt_q == 16'h0001 && qual_edge |=> cnt_q == 16'h0000 && !$rose(timer_irq_pending_r))
        else $error("event count did not sit at zero");
    cap_flags_a: assert property (cap_mode && cnt_uflow && cap_evt |=>
        run_or_underflow_flag_r && timer_irq_pending_r)
        else $error("capture mode flags not both set");
    stopped_a: assert property (!cap_mode && !run_or_underflow_flag_r && !cnt_wr
        |=> $stable(cnt_q))
        else $error("counter ran while stopped");
    irq_gate_a: assert property (pend_any && timer_irq_enable_r
        && global_irq_enable_r |=> timer_irq)
        else $error("interrupt not raised");
    irq_mask_a: assert property (!global_irq_enable_r || !timer_irq_enable_r
        |=> !timer_irq)
        else $error("interrupt raised while masked");
    edge_live_a: assert property (cap_mode && edge_select_bit_r && pin_fall
        |=> timer_irq_pending_r)
        else $error("falling capture edge missed");
    cap_wrap_a: assert property (cap_mode && cnt_uflow |=>
        run_or_underflow_flag_r && cnt_q == `DTC_CNT_RST)
        else $error("capture underflow did not wrap and flag");
    event_step_a: assert property (evt_mode && run_or_underflow_flag_r && qual_edge
        && !cnt_wr && cnt_q != 16'h0000 |=> cnt_q == $past(cnt_q) - 16'h0001)
        else $error("event edge did not step the count");
    edge_pulse_a: assert property (pin_rise || pin_fall |=>
        !pin_rise && !pin_fall)
        else $error("pin edge pulse longer than one cycle");
    capture_irq_a: assert property (cap_evt && timer_irq_enable_r && global_irq_enable_r
        && !ctrl_wr && !gie_wr |-> ##2 timer_irq)
        else $error("capture did not raise the interrupt");

    cap_seen_c:  cover property (cap_evt);
    uflow_evt_c: cover property (evt_mode && cnt_uflow);
    both_c:      cover property (cap_mode && cnt_uflow && cap_evt);
    mode_c:      cover property (mode == dtc_pkg::DTC_RLD);
    edge_fall_c: cover property (cap_mode && edge_select_bit_r && cap_evt);
endmodule // dtc_timer

// [design/dtc_consts.svh]
// Constants of the down timer: register map, field positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus, one aligned word per register.
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

`define DTC_ADDR_CTRL   8'h00
`define DTC_ADDR_COUNT  8'h04
`define DTC_ADDR_RELCAP 8'h08
`define DTC_ADDR_GIE    8'h0C

`define DTC_BIT_PWM     7
`define DTC_BIT_CAP     6
`define DTC_BIT_EDGE    5
`define DTC_BIT_RUN     4
`define DTC_BIT_PEND    3
`define DTC_BIT_EN      2
`define DTC_BIT_GIE     0

`define DTC_CNT_RST     16'hFFFF
`define DTC_RC_RST      16'h0000
`define DTC_RESP_OKAY   2'h0
`define DTC_RESP_SLVERR 2'h2

`endif

// [design/dtc_pkg.sv]
// Types of the down timer: mode codes, register selection, bus states.
// Assumes dtc_consts.svh for numeric constants.
package dtc_pkg;
    typedef enum logic [2:0] {
        DTC_EVT_RISE = 3'h0,
        DTC_EVT_FALL = 3'h1,
        DTC_CAP_RISE = 3'h2,
        DTC_CAP_FALL = 3'h3,
        DTC_RLD      = 3'h4,
        DTC_RLD_TGL  = 3'h5
    } dtc_mode_t;

    typedef enum logic [2:0] {
        DTC_SEL_CTRL, DTC_SEL_COUNT, DTC_SEL_RELCAP, DTC_SEL_GIE, DTC_SEL_NONE
    } dtc_sel_t;

    typedef enum logic [1:0] {
        DTC_BUS_IDLE = 2'h0,
        DTC_BUS_RESP = 2'h1
    } dtc_bus_t;
endpackage

// [design/dtc_pin_sync.sv]
// Pin synchroniser and edge detector for the timer pin.
// Assumes an asynchronous pin; a level counts once stages two and three agree.
`timescale 1ns/1ps
module dtc_pin_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      rise_r,
    output logic      fall_r
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;
    wire  agree = (s2_r == s3_r);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_r   <= 1'b0;
            s2_r   <= 1'b0;
            s3_r   <= 1'b0;
            lvl_r  <= 1'b0;
            rise_r <= 1'b0;
            fall_r <= 1'b0;
        end else begin
            s1_r   <= pin;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            lvl_r  <= agree ? s3_r : lvl_r;
            rise_r <= agree && s3_r && !lvl_r;
            fall_r <= agree && !s3_r && lvl_r;
        end
    end
endmodule // dtc_pin_sync

// [design/dtc_down_counter.sv]
// Loadable 16-bit down counter with reload or wrap on underflow.
// Assumes load has priority over a decrement in the same cycle.
`timescale 1ns/1ps
`include "dtc_consts.svh"
module dtc_down_counter #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         load_en,
    input  wire logic [W-1:0] load_val,
    input  wire logic         dec_en,
    input  wire logic         use_reload,
    input  wire logic [W-1:0] reload_val,
    output logic      [W-1:0] cnt_r,
    output logic              uflow
);
    logic [W-1:0] cnt_nxt;

    assign uflow = dec_en && (cnt_r == '0);

    always_comb begin
        cnt_nxt = cnt_r;
        if (load_en) begin
            cnt_nxt = load_val;
        end else if (uflow) begin
            cnt_nxt = use_reload ? reload_val : '1;
        end else if (dec_en) begin
            cnt_nxt = cnt_r - W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= W'(`DTC_CNT_RST);
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule // dtc_down_counter

// [verification/dtc_pin_src.sv]
// External event source that drives the timer pin.
// Assumes the tb calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
module dtc_pin_src (
    input  wire logic clk,
    output logic      pin
);
    initial pin = 1'b0;

    // Each level is held for hold cycles; a hold of zero gives levels shorter than one cycle
    task automatic pulses(input int n, input int hold);
        repeat (n) begin
            repeat (hold) @(posedge clk);
            pin <= 1'b1;
            repeat (hold) @(posedge clk);
            pin <= 1'b0;
        end
    endtask
endmodule // dtc_pin_src

// [verification/tb.sv]
// Testbench of the down timer: AXI4-Lite tasks, event and capture tests.
// Assumes dtc_timer at its default address width and the pin source model.
`timescale 1ns/1ps
`include "dtc_consts.svh"
module tb;
    logic        aclk, aresetn, timer_pin, timer_irq;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, a, b, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  rmode [2] = '{8'h90, 8'hB0};
    int          num_errors, total_checks;

    dtc_timer i_dtc_timer (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_pin, .timer_irq
    );
    dtc_pin_src i_dtc_pin_src (.clk(aclk), .pin(timer_pin));

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_irq(input logic exp);
        chk({31'h0, timer_irq}, {31'h0, exp}, "irq");
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr  <= ad;
        s_axi_wdata   <= dt;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) aw = 1'b0;
            if (s_axi_wready === 1'b1) w = 1'b0;
            s_axi_awvalid <= aw;
            s_axi_wvalid  <= w;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        chk({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
    endtask

    task automatic rd(input logic [7:0] ad, input logic [1:0] er, output logic [31:0] dt);
        s_axi_araddr  <= ad;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        dt = s_axi_rdata;
        chk({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
    endtask

    task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
        logic [31:0] v;
        rd(ad, `DTC_RESP_OKAY, v);
        chk(v, exp, "read");
    endtask

    task automatic test_done(input string name);
        $display("Test %s done, errors %0d", name, num_errors);
    endtask

    task automatic stop_test;
        $display("Checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        $display("Error at %0t: timeout", $time);
        stop_test();
    end

    initial begin
        aresetn = 1'b0;
        // Response readies stay high for the whole run
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h05;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata  = 32'h0000_0000;
        s_axi_wstrb  = 4'hF;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(`DTC_ADDR_COUNT, 32'h0000_FFFF);
        rchk(`DTC_ADDR_RELCAP, 32'h0000_0000);
        rchk(`DTC_ADDR_CTRL, 32'h0000_0000);
        chk_irq(1'b0);
        wr(8'h10, 32'h0000_00FF, `DTC_RESP_SLVERR);
        rd(8'h10, `DTC_RESP_SLVERR, d);
        chk(d, 32'h0000_0000, "unmapped");
        test_done("reset");
        // Event counting, two events to zero, third underflows
        wr(`DTC_ADDR_COUNT, 32'h0000_0002, `DTC_RESP_OKAY);
        wr(`DTC_ADDR_RELCAP, 32'h0000_0002, `DTC_RESP_OKAY);
        wr(`DTC_ADDR_CTRL, 32'h0000_0004, `DTC_RESP_OKAY);
        wr(`DTC_ADDR_GIE, 32'h0000_0001, `DTC_RESP_OKAY);
        wr(`DTC_ADDR_CTRL, 32'h0000_0014, `DTC_RESP_OKAY);
        i_dtc_pin_src.pulses(2, 3);
        cyc(8);
        rchk(`DTC_ADDR_COUNT, 32'h0000_0000);
        chk_irq(1'b0);
        i_dtc_pin_src.pulses(1, 3);
        cyc(8);
        rchk(`DTC_ADDR_COUNT, 32'h0000_0002);
        rchk(`DTC_ADDR_CTRL, 32'h0000_001C);
        chk_irq(1'b1);
        wr(`DTC_ADDR_GIE, 32'h0000_0000, `DTC_RESP_OKAY);
        cyc(3);
        chk_irq(1'b0);
        wr(`DTC_ADDR_GIE, 32'h0000_0001, `DTC_RESP_OKAY);
        wr(`DTC_ADDR_CTRL, 32'h0000_0014, `DTC_RESP_OKAY);
        cyc(3);
        chk_irq(1'b0);
        wr(`DTC_ADDR_COUNT, 32'h0000_0001, `DTC_RESP_OKAY);
        wr(`DTC_ADDR_CTRL, 32'h0000_0034, `DTC_RESP_OKAY);
        i_dtc_pin_src.pulses(2, 3);
        cyc(8);
        rchk(`DTC_ADDR_COUNT, 32'h0000_0002);
        rchk(`DTC_ADDR_CTRL, 32'h0000_003C);
        wr(`DTC_ADDR_CTRL, 32'h0000_0004, `DTC_RESP_OKAY);
        i_dtc_pin_src.pulses(2, 3);
        cyc(8);
        rchk(`DTC_ADDR_COUNT, 32'h0000_0002);
        test_done("event");
        // Capture a pulse width with live edge reselection
        wr(`DTC_ADDR_COUNT, 32'h0000_FFFF, `DTC_RESP_OKAY);
        wr(`DTC_ADDR_CTRL, 32'h0000_0044, `DTC_RESP_OKAY);
        fork
            i_dtc_pin_src.pulses(1, 60);
        join_none
        @(posedge timer_pin);
        cyc(8);
        rd(`DTC_ADDR_RELCAP, `DTC_RESP_OKAY, a);
        rchk(`DTC_ADDR_CTRL, 32'h0000_004C);
        chk_irq(1'b1);
        wr(`DTC_ADDR_CTRL, 32'h0000_0064, `DTC_RESP_OKAY);
        cyc(2);
        chk_irq(1'b0);
        @(negedge timer_pin);
        cyc(8);
        rd(`DTC_ADDR_RELCAP, `DTC_RESP_OKAY, b);
        chk({16'h0, a[15:0] - b[15:0]}, 32'h0000_003C, "width");
        rchk(`DTC_ADDR_CTRL, 32'h0000_006C);
        wr(`DTC_ADDR_COUNT, 32'h0000_0010, `DTC_RESP_OKAY);
        cyc(30);
        rchk(`DTC_ADDR_CTRL, 32'h0000_007C);
        chk_irq(1'b1);
        rd(`DTC_ADDR_COUNT, `DTC_RESP_OKAY, d);
        chk({31'h0, d[15:0] > 16'hFF00}, 32'h1, "wrap");
        wr(`DTC_ADDR_CTRL, 32'h0000_0064, `DTC_RESP_OKAY);
        cyc(2);
        chk_irq(1'b0);
        rd(`DTC_ADDR_COUNT, `DTC_RESP_OKAY, a);
        rd(`DTC_ADDR_COUNT, `DTC_RESP_OKAY, b);
        chk({31'h0, a !== b}, 32'h1, "running");
        wr(`DTC_ADDR_CTRL, 32'h0000_0000, `DTC_RESP_OKAY);
        rd(`DTC_ADDR_COUNT, `DTC_RESP_OKAY, a);
        cyc(5);
        rd(`DTC_ADDR_COUNT, `DTC_RESP_OKAY, b);
        chk(b, a, "stopped");
        test_done("capture");
        // Clock-driven reload modes, with and without toggle
        foreach (rmode[i]) begin
            wr(`DTC_ADDR_RELCAP, 32'h0000_0100, `DTC_RESP_OKAY);
            wr(`DTC_ADDR_COUNT, 32'h0000_0003, `DTC_RESP_OKAY);
            wr(`DTC_ADDR_CTRL, {24'h0, rmode[i]}, `DTC_RESP_OKAY);
            cyc(20);
            rd(`DTC_ADDR_COUNT, `DTC_RESP_OKAY, d);
            wr(`DTC_ADDR_CTRL, 32'h0000_0000, `DTC_RESP_OKAY);
            chk({31'h0, d[15:0] > 16'h00E0 && d[15:0] <= 16'h0100}, 32'h1, "reload");
        end
        test_done("reload");
        stop_test();
    end
endmodule // tb
